// ==== pkg/boot_clock_pkg.sv ====
package boot_clock_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CFG_WORD  = 8'h00;
  localparam logic [7:0] OFF_PLL_WORD  = 8'h04;
  localparam logic [7:0] OFF_CONTROL   = 8'h08;
  localparam logic [7:0] OFF_UNLOCK    = 8'h0C;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_SYS_FREQ  = 8'h14;
  localparam logic [7:0] OFF_PB_FREQ   = 8'h18;
  // Field positions in the clock configuration word.
  localparam int SWITCH_CFG_LSB = 14;
  localparam int PB_DIV_LSB     = 12;
  localparam int CLK_OUT_BIT    = 10;
  localparam int OSC_MODE_LSB   = 8;
  localparam int TWO_SPEED_BIT  = 7;
  localparam int SEC_OSC_BIT    = 5;
  localparam int SOURCE_LSB     = 0;
  // Field positions in the PLL configuration word.
  localparam int POST_DIV_LSB   = 16;
  localparam int MULT_LSB       = 4;
  localparam int IN_DIV_LSB     = 0;
  // Field positions in the control register.
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_POST_LSB  = 3;
  localparam int CTRL_SWITCH    = 8;
  // Unlock keys; the values are arbitrary.
  localparam logic [31:0] UNLOCK_KEY_A = 32'h5A5A_0001;
  localparam logic [31:0] UNLOCK_KEY_B = 32'hA5A5_0002;
  // Fixed internal divide of the sixteenth fast RC mode, as a shift.
  localparam int FRC_SIXTEEN_SHIFT = 4;
  // Read data for an unmapped address and the default before the address decodes.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Source codes of the boot source field.
  typedef enum logic [2:0] {
    SRC_FRC      = 3'b000,
    SRC_FRC_PLL  = 3'b001,
    SRC_PRIMARY_OSCILLATOR     = 3'b010,
    SRC_PRIMARY_OSCILLATOR_PLL = 3'b011,
    SRC_SECONDARY_OSCILLATOR     = 3'b100,
    SRC_LOW_POWER_INTERNAL_RC     = 3'b101,
    SRC_FRC_DIV16 = 3'b110,
    SRC_FRC_DIVN = 3'b111
  } source_t;

  // Unlock sequencer states.
  typedef enum logic [2:0] {
    LOCKED   = 3'b001,
    KEY_SEEN = 3'b010,
    OPENED   = 3'b100
  } unlock_t;

  // Bus request from the master.
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  // Bus answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // Frequencies of the four oscillators in kHz.
  typedef struct packed {
    logic [31:0] primaryKhz;
    logic [31:0] secondaryKhz;
    logic [31:0] fastRcKhz;
    logic [31:0] lowPowerRcKhz;
  } osc_freq_t;

  // Decoded oscillator controls.
  typedef struct packed {
    logic    primaryEnable;
    logic    highGainMode;
    logic    mediumGainMode;
    logic    extClockMode;
    logic    secondaryEnable;
    logic    twoSpeedStartup;
    logic    clockFailMonitor;
    logic    clockSwitchEnable;
    source_t activeSource;
  } osc_ctrl_t;
endpackage : boot_clock_pkg

// ==== rtl/boot_clock_config_decoder.sv ====
`timescale 1ns/1ps
module boot_clock_config_decoder #(
  parameter int FRC_DIV_N = 1  // Divide applied in the fast RC divide-by-N mode.
) (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic [31:0]               bootClockWord,
  input  wire logic [31:0]               bootPllWord,
  input  wire boot_clock_pkg::osc_freq_t oscFreq,
  input  wire boot_clock_pkg::apb_req_t  apbReq,
  output boot_clock_pkg::apb_rsp_t       apbRsp,
  output boot_clock_pkg::osc_ctrl_t      oscCtrl,
  output logic [31:0]                    systemClockKhz,
  output logic [31:0]                    periphBusClockKhz,
  output logic                           periphBusTick,
  output logic                           oscOutPinOut,
  output logic                           oscOutPinOe
);

  // Everything that remembers anything lives in this record, so the reset branch
  // and the register process stay short and no stray flop can escape reset.
  // The boot words are copied whole; decoding them from the copy keeps the
  // reserved bits visible on the bus for software that wants to inspect them.
  // Whole state of the block in one record.
  typedef struct packed {
    logic [31:0]             cfgWord;     // Boot clock word as sampled in reset.
    logic [31:0]             pllWord;     // Boot PLL word as sampled in reset.
    boot_clock_pkg::source_t activeSrc;   // Source now driving the clocks.
    logic [2:0]              reqSrc;      // Last source requested by software.
    logic [2:0]              postDiv;     // Runtime PLL post divider code.
    boot_clock_pkg::unlock_t lockState;   // Unlock sequencer.
    logic [31:0]             sysFreq;     // System clock frequency in kHz.
    logic [31:0]             pbFreq;      // Bus clock frequency in kHz.
    logic [7:0]              pbCount;     // Bus clock divide counter.
    logic                    pbTick;      // One-cycle bus clock enable.
    logic                    pbPhase;     // Bus clock square wave.
    logic [31:0]             rdData;      // Read data caught in setup.
    logic                    rdErr;       // Unmapped address caught in setup.
  } state_t;

  // One copy is registered and one is computed; nothing else holds state.
  state_t st_r;   // Registered state.
  state_t st_nxt; // Next state.

  // Fields decoded from the held boot words.
  // They are plain wires off the frozen copy, so they cannot move after reset
  // even if the boot word pins start to wander.
  logic [1:0] switchCfg;     // Monitor and switch configuration field.
  logic [1:0] pbDivCode;     // Default bus clock divisor code.
  logic [1:0] oscMode;       // Primary oscillator mode field.
  logic       switchAllowed; // High when software may change the source.

  // Codes six and seven jump to ten and twelve; the rest are the code plus one.
  // A divider of zero cannot occur, so the later division is always defined.
  // Input divider of the PLL reference.
  function automatic logic [3:0] inDivValue(input logic [2:0] code);
    case (code)
      3'b110:  inDivValue = 4'd10;
      3'b111:  inDivValue = 4'd12;
      default: inDivValue = 4'({1'b0, code} + 4'd1);
    endcase
  endfunction : inDivValue

  // The multiplier climbs by one per code and skips to twenty-four at the top.
  // Five bits are enough for the largest value.
  // PLL multiplier.
  function automatic logic [4:0] multValue(input logic [2:0] code);
    if (code == 3'b111) begin
      multValue = 5'd24;
    end else begin
      multValue = 5'({2'b00, code} + 5'd15);
    end
  endfunction : multValue

  // Every divide is a power of two, so a shift replaces a real divider.
  // The top code skips from sixty-four straight to two hundred fifty-six.
  // Post divider expressed as a right shift.
  function automatic logic [3:0] postShift(input logic [2:0] code);
    if (code == 3'b111) begin
      postShift = 4'd8;
    end else begin
      postShift = {1'b0, code};
    end
  endfunction : postShift

  // The reference is divided before it is multiplied, which truncates early;
  // the product is widened so twenty-four times a large reference cannot
  // overflow before the post shift.
  // PLL output frequency from a reference frequency.
  function automatic logic [31:0] pllFreq(input logic [31:0] refKhz, input logic [31:0] pllWord,
                                          input logic [2:0] post);
    logic [39:0] prod;
    prod = 40'(refKhz / 32'(inDivValue(pllWord[boot_clock_pkg::IN_DIV_LSB +: 3])))
         * 40'(multValue(pllWord[boot_clock_pkg::MULT_LSB +: 3]));
    pllFreq = 32'(prod >> postShift(post));
  endfunction : pllFreq

  // Kept apart from the main process so both later processes read the same names.
  // Field extraction from the held words.
  always_comb begin
    switchCfg     = st_r.cfgWord[boot_clock_pkg::SWITCH_CFG_LSB +: 2];
    pbDivCode     = st_r.cfgWord[boot_clock_pkg::PB_DIV_LSB +: 2];
    oscMode       = st_r.cfgWord[boot_clock_pkg::OSC_MODE_LSB +: 2];
    // Only an upper bit of zero lets software switch sources.
    // Both values with the upper bit set behave the same way.
    switchAllowed = ~switchCfg[1];
  end

  // Start from the present state so every field holds unless a branch below
  // moves it; this also keeps the process free of latches.
  // The locals get defaults first so no path leaves them undriven.
  // Next-state logic: bus slave, unlock, switching, frequencies and divider.
  always_comb begin
    logic [31:0] srcKhz;
    logic [7:0]  pbDivLast;
    logic        wrEn;
    srcKhz    = 32'h0000_0000;
    pbDivLast = 8'h00;
    wrEn      = 1'b0;
    st_nxt    = st_r;

    // A write lands only at the access edge, where pready is always high.
    // Setup cycles never write, so a request is applied exactly once.
    wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;

    // Read data and error are caught in the setup cycle so they come from flops.
    // The trade is that read data is one cycle old, which is harmless for
    // configuration that changes so rarely.
    if (apbReq.psel && !apbReq.penable) begin
      st_nxt.rdErr  = 1'b0;
      st_nxt.rdData = boot_clock_pkg::RESET_WORD;
      case (apbReq.paddr)
        boot_clock_pkg::OFF_CFG_WORD: begin
          st_nxt.rdData = st_r.cfgWord;
        end
        boot_clock_pkg::OFF_PLL_WORD: begin
          st_nxt.rdData = st_r.pllWord;
        end
        boot_clock_pkg::OFF_CONTROL: begin
          // The switch bit is a strobe and always reads as zero.
          st_nxt.rdData = {23'h0, 1'b0, 2'b00, st_r.postDiv, st_r.reqSrc};
        end
        boot_clock_pkg::OFF_UNLOCK: begin
          // Keys are write only; reading shows the sequencer instead.
          st_nxt.rdData = {29'h0, st_r.lockState};
        end
        boot_clock_pkg::OFF_STATUS: begin
          st_nxt.rdData = {22'h0, switchAllowed, st_r.lockState == boot_clock_pkg::OPENED,
                           st_r.postDiv, 2'b00, st_r.activeSrc};
        end
        boot_clock_pkg::OFF_SYS_FREQ: begin
          st_nxt.rdData = st_r.sysFreq;
        end
        boot_clock_pkg::OFF_PB_FREQ: begin
          st_nxt.rdData = st_r.pbFreq;
        end
        default: begin
          // Unmapped addresses read zero and flag an error.
          // Writes there store nothing, though one after a key still relocks the sequencer.
          st_nxt.rdErr = 1'b1;
        end
      endcase
    end

    // Reads do not touch the sequencer, so software may poll status between keys.
    // A wrong write in the middle starts the sequence over from the first key.
    // Unlock sequencer: two keys back to back, any other write relocks.
    if (wrEn) begin
      case (st_r.lockState)
        boot_clock_pkg::LOCKED: begin
          // Only the first key at the key address arms the sequencer.
          if (apbReq.paddr == boot_clock_pkg::OFF_UNLOCK && apbReq.pwdata == boot_clock_pkg::UNLOCK_KEY_A) begin
            st_nxt.lockState = boot_clock_pkg::KEY_SEEN;
          end
        end
        boot_clock_pkg::KEY_SEEN: begin
          if (apbReq.paddr == boot_clock_pkg::OFF_UNLOCK && apbReq.pwdata == boot_clock_pkg::UNLOCK_KEY_B) begin
            st_nxt.lockState = boot_clock_pkg::OPENED;
          end else begin
            st_nxt.lockState = boot_clock_pkg::LOCKED;
          end
        end
        boot_clock_pkg::OPENED: begin
          // Any write after the keys closes the lock again, so each change needs fresh keys.
          st_nxt.lockState = boot_clock_pkg::LOCKED;
          if (apbReq.paddr == boot_clock_pkg::OFF_CONTROL) begin
            st_nxt.reqSrc  = apbReq.pwdata[boot_clock_pkg::CTRL_SRC_LSB +: 3];
            st_nxt.postDiv = apbReq.pwdata[boot_clock_pkg::CTRL_POST_LSB +: 3];
            // Source changes are dropped when the boot word forbids switching.
            // The post divider and requested code are still stored; status shows the divider, the control register the code.
            if (apbReq.pwdata[boot_clock_pkg::CTRL_SWITCH] && switchAllowed) begin
              st_nxt.activeSrc = boot_clock_pkg::source_t'(apbReq.pwdata[boot_clock_pkg::CTRL_SRC_LSB +: 3]);
            end
          end
        end
        default: begin
          // An illegal one-hot code falls back to the safe locked state.
          st_nxt.lockState = boot_clock_pkg::LOCKED;
        end
      endcase
    end

    // The figures are bookkeeping for software, not real clocks; they are
    // registered so the bus reads a stable value one cycle after a switch.
    // Frequency of the active mode; every mode maps to one of four oscillators.
    case (st_r.activeSrc)
      boot_clock_pkg::SRC_FRC: begin
        srcKhz = oscFreq.fastRcKhz;
      end
      boot_clock_pkg::SRC_FRC_PLL: begin
        srcKhz = pllFreq(oscFreq.fastRcKhz, st_r.pllWord, st_r.postDiv);
      end
      boot_clock_pkg::SRC_PRIMARY_OSCILLATOR: begin
        srcKhz = oscFreq.primaryKhz;
      end
      boot_clock_pkg::SRC_PRIMARY_OSCILLATOR_PLL: begin
        srcKhz = pllFreq(oscFreq.primaryKhz, st_r.pllWord, st_r.postDiv);
      end
      boot_clock_pkg::SRC_SECONDARY_OSCILLATOR: begin
        srcKhz = oscFreq.secondaryKhz;
      end
      boot_clock_pkg::SRC_LOW_POWER_INTERNAL_RC: begin
        srcKhz = oscFreq.lowPowerRcKhz;
      end
      boot_clock_pkg::SRC_FRC_DIV16: begin
        // A fixed divide by sixteen is a plain shift.
        srcKhz = oscFreq.fastRcKhz >> boot_clock_pkg::FRC_SIXTEEN_SHIFT;
      end
      default: begin
        // Divide-by-N mode; the parameter must never be zero.
        srcKhz = oscFreq.fastRcKhz / 32'(FRC_DIV_N);
      end
    endcase
    // Both clocks come from the same source, so a switch moves both.
    // The bus figure truncates, as a real divider would drop the remainder.
    st_nxt.sysFreq = srcKhz;
    st_nxt.pbFreq  = srcKhz >> pbDivCode;

    // The counter compares with greater-or-equal so a stray count above the
    // limit recovers at once instead of wrapping through all 256 values.
    // The phase bit toggles on each tick and feeds the clock out pin.
    // Bus clock enable: one tick every 1, 2, 4 or 8 cycles.
    pbDivLast = 8'((8'h01 << pbDivCode) - 8'h01);
    if (st_r.pbCount >= pbDivLast) begin
      st_nxt.pbCount = 8'h00;
      st_nxt.pbTick  = 1'b1;
      st_nxt.pbPhase = ~st_r.pbPhase;
    end else begin
      st_nxt.pbCount = 8'(st_r.pbCount + 8'h01);
      st_nxt.pbTick  = 1'b0;
    end
  end

  // The reset is synchronous, so sampling the boot pins in the reset branch is
  // safe: they are treated as levels that settle long before reset is released.
  // Clearing the record first and then overwriting a few fields keeps every
  // unnamed field at zero without listing it.
  // State register; boot words are caught while reset is held and frozen after.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r           <= '0;
      st_r.cfgWord   <= bootClockWord;
      st_r.pllWord   <= bootPllWord;
      // Reserved bits are never decoded, so their programmed value has no effect here.
      // Runtime copies start from the boot fields so software sees the defaults.
      st_r.activeSrc <= boot_clock_pkg::source_t'(bootClockWord[boot_clock_pkg::SOURCE_LSB +: 3]);
      st_r.reqSrc    <= bootClockWord[boot_clock_pkg::SOURCE_LSB +: 3];
      st_r.postDiv   <= bootPllWord[boot_clock_pkg::POST_DIV_LSB +: 3];
      st_r.lockState <= boot_clock_pkg::LOCKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pready is tied high: the slave never inserts a wait state.
  // Read data comes straight from a flop; only the error flag is gated by the
  // bus phase so it shows during the access cycle alone.
  // Output decode of the held configuration.
  always_comb begin
    apbRsp.prdata  = st_r.rdData;
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbReq.psel & apbReq.penable & st_r.rdErr;

    oscCtrl.primaryEnable     = oscMode != 2'b11;
    oscCtrl.highGainMode      = oscMode == 2'b10;
    oscCtrl.mediumGainMode    = oscMode == 2'b01;
    oscCtrl.extClockMode      = oscMode == 2'b00;
    oscCtrl.secondaryEnable   = st_r.cfgWord[boot_clock_pkg::SEC_OSC_BIT];
    oscCtrl.twoSpeedStartup   = st_r.cfgWord[boot_clock_pkg::TWO_SPEED_BIT];
    oscCtrl.clockFailMonitor  = switchCfg == 2'b00;
    oscCtrl.clockSwitchEnable = switchAllowed;
    oscCtrl.activeSource      = st_r.activeSrc;

    systemClockKhz    = st_r.sysFreq;
    periphBusClockKhz = st_r.pbFreq;
    periphBusTick     = st_r.pbTick;

    // The pin is free for clock out only when no crystal uses it.
    // The enable stays low in either crystal mode, where the pin carries feedback.
    oscOutPinOe  = st_r.cfgWord[boot_clock_pkg::CLK_OUT_BIT]
                 & (oscMode == 2'b11 || oscMode == 2'b00);
    oscOutPinOut = st_r.pbPhase & oscOutPinOe;
  end

endmodule : boot_clock_config_decoder

// ==== tb/boot_clock_config_decoder_assertions.sv ====
`timescale 1ns/1ps
module boot_clock_config_decoder_assertions #(
  parameter int FRC_DIV_N = 1  // Divide of the divide-by-N mode.
) (
  input wire logic                      clock,
  input wire logic                      reset_n,
  input wire logic [31:0]               bootClockWord,
  input wire logic [31:0]               bootPllWord,
  input wire boot_clock_pkg::osc_freq_t oscFreq,
  input wire boot_clock_pkg::apb_req_t  apbReq,
  input wire boot_clock_pkg::apb_rsp_t  apbRsp,
  input wire boot_clock_pkg::osc_ctrl_t oscCtrl,
  input wire logic [31:0]               systemClockKhz,
  input wire logic [31:0]               periphBusClockKhz,
  input wire logic                      periphBusTick,
  input wire logic                      oscOutPinOut,
  input wire logic                      oscOutPinOe
);
  logic [31:0] cfg_r;   // Boot word as captured during reset.
  logic [3:0]  gap_r;   // Cycles since the last bus tick.
  logic        seen_r;  // Set once a first tick was seen.
  logic [31:0] srcKhz;  // Expected frequency of a source without PLL.
  logic        noPll;   // The active source bypasses the PLL.

  // The word is captured only under reset, so later changes must not show.
  always_ff @(posedge clock) begin
    if (!reset_n) cfg_r <= bootClockWord;
  end

  // Tick spacing counter; saturates so a stuck tick cannot wrap into a pass.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gap_r <= 4'h0;
      seen_r <= 1'b0;
    end else if (periphBusTick) begin
      gap_r <= 4'h1;
      seen_r <= 1'b1;
    end else if (gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end

  // Frequency each non-PLL source should give.
  always_comb begin
    noPll = 1'b1;
    case (oscCtrl.activeSource)
      boot_clock_pkg::SRC_FRC:       srcKhz = oscFreq.fastRcKhz;
      boot_clock_pkg::SRC_PRIMARY_OSCILLATOR:      srcKhz = oscFreq.primaryKhz;
      boot_clock_pkg::SRC_SECONDARY_OSCILLATOR:      srcKhz = oscFreq.secondaryKhz;
      boot_clock_pkg::SRC_LOW_POWER_INTERNAL_RC:      srcKhz = oscFreq.lowPowerRcKhz;
      boot_clock_pkg::SRC_FRC_DIV16: srcKhz = oscFreq.fastRcKhz >> 4;
      boot_clock_pkg::SRC_FRC_DIVN:  srcKhz = oscFreq.fastRcKhz / 32'(FRC_DIV_N);
      default: begin
        srcKhz = 32'h0000_0000;
        noPll = 1'b0;
      end
    endcase
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence bootRelease;
    $rose(reset_n);
  endsequence

  a_switch_decode: assert property (oscCtrl.clockSwitchEnable == !cfg_r[15]
    && oscCtrl.clockFailMonitor == (cfg_r[15:14] == 2'b00)) else $error("Switch enables wrong.");
  a_mode_decode: assert property (oscCtrl.primaryEnable == (cfg_r[9:8] != 2'b11)
    && oscCtrl.highGainMode == (cfg_r[9:8] == 2'b10) && oscCtrl.mediumGainMode == (cfg_r[9:8] == 2'b01)
    && oscCtrl.extClockMode == (cfg_r[9:8] == 2'b00)) else $error("Oscillator mode wrong.");
  a_clkout_gate: assert property (oscOutPinOe == (cfg_r[10]
    && (cfg_r[9:8] == 2'b11 || cfg_r[9:8] == 2'b00))) else $error("Clock out enable wrong.");
  a_start_bits: assert property (oscCtrl.twoSpeedStartup == cfg_r[7]
    && oscCtrl.secondaryEnable == cfg_r[5]) else $error("Start-up bits wrong.");
  a_tick_gap: assert property (periphBusTick && seen_r |-> gap_r == (4'h1 << cfg_r[13:12]))
    else $error("Bus tick spacing wrong.");
  a_pb_follow: assert property ($past(reset_n, 2) && $stable(systemClockKhz)
    |-> periphBusClockKhz == systemClockKhz >> cfg_r[13:12]) else $error("Bus clock frequency wrong.");
  a_sys_follow: assert property ($past(reset_n, 2) && $past(noPll)
    |-> systemClockKhz == $past(srcKhz)) else $error("System clock frequency wrong.");
  a_switch_locked: assert property (cfg_r[15] && $past(reset_n) |-> $stable(oscCtrl.activeSource))
    else $error("Source moved while switching is off.");
  a_clkout_wave: assert property ($past(reset_n, 2) && $past(oscOutPinOe)
    |-> (oscOutPinOut == (oscOutPinOe && ($past(oscOutPinOut) != periphBusTick))))
    else $error("Clock out wave wrong.");
  a_boot_source: assert property (bootRelease |-> ##1 oscCtrl.activeSource == cfg_r[2:0])
    else $error("Boot source not applied.");
endmodule : boot_clock_config_decoder_assertions

// ==== tb/boot_clock_config_decoder_tb.sv ====
`timescale 1ns/1ps
module boot_clock_config_decoder_tb;
  localparam int DIV_N = 3;  // Non-unit so the divide-by-N mode shows.
  localparam logic [31:0] PRI = 32'h0000_9C40;
  localparam logic [31:0] SEC = 32'h0000_0020;
  localparam logic [31:0] FAST_INTERNAL_RC = 32'h0000_1F40;
  localparam logic [31:0] LPR = 32'h0000_001F;
  localparam logic [31:0] CTRL = 32'h0000_012C;  // Switch bit, post code 5, source SECONDARY_OSCILLATOR.
  int IDIV[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int MUL[8]  = '{15, 16, 17, 18, 19, 20, 21, 24};
  int POST[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  logic clock, reset_n, tick, pinOut, pinOe, rerr;
  logic [31:0] clockWord, pllWord, sysKhz, pbKhz, rdata;
  boot_clock_pkg::osc_freq_t oscFreq;
  boot_clock_pkg::apb_req_t  apbReq;
  boot_clock_pkg::apb_rsp_t  apbRsp;
  boot_clock_pkg::osc_ctrl_t oscCtrl;
  int failures, checkCount;

  boot_clock_config_decoder #(.FRC_DIV_N(DIV_N)) DUT (.clock(clock), .reset_n(reset_n),
    .bootClockWord(clockWord), .bootPllWord(pllWord), .oscFreq(oscFreq), .apbReq(apbReq),
    .apbRsp(apbRsp), .oscCtrl(oscCtrl), .systemClockKhz(sysKhz), .periphBusClockKhz(pbKhz),
    .periphBusTick(tick), .oscOutPinOut(pinOut), .oscOutPinOe(pinOe));

  always #5 clock = ~clock;

  task automatic completeRun;
    $display("failures=%0d checks=%0d", failures, checkCount);
    if (failures == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : completeRun

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checkCount++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  // One bus transfer; waits for pready as long as it takes, takes data at that edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    apbReq <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  // Frequency worked out from the source code, PLL codes and post code.
  function automatic logic [31:0] expKhz(input logic [2:0] s, input logic [2:0] d, input logic [2:0] k,
                                         input logic [2:0] p);
    logic [31:0] base;
    base = (s == 3'b001) ? FAST_INTERNAL_RC : oscFreq.primaryKhz;
    case (s)
      3'b000: return FAST_INTERNAL_RC;
      3'b001, 3'b011: return 32'(base / IDIV[d] * MUL[k] / POST[p]);
      3'b010: return oscFreq.primaryKhz;
      3'b100: return SEC;
      3'b101: return LPR;
      3'b110: return FAST_INTERNAL_RC >> 4;
      default: return 32'(FAST_INTERNAL_RC / DIV_N);
    endcase
  endfunction : expKhz

  // Boots one configuration, checks decode, then tries a locked and an unlocked switch.
  task automatic bootAndCheck(input logic [3:0] i);
    logic [31:0] cw, pw;
    logic [2:0]  k, src, newSrc, d;
    k = {i[1:0], i[3]};
    src = i[2:0];
    d = (src == 3'b001) ? 3'b001 : k;
    oscFreq.primaryKhz <= 32'(4500 * IDIV[d]);
    cw = {16'hFFFF, i[1:0], i[2:1], 1'b1, i[0], i[3:2], i[1], 1'b1, i[3], 2'b11, src};
    pw = {13'h1FFF, k, 8'hFF, 1'b1, k, 1'b1, d};
    reset_n <= 1'b0;
    clockWord <= cw;
    pllWord <= pw;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    clockWord <= ~cw;
    pllWord <= ~pw;
    repeat (3) @(posedge clock);
    apb(1'b1, boot_clock_pkg::OFF_CFG_WORD, 32'h0000_0000);
    apb(1'b0, boot_clock_pkg::OFF_CFG_WORD, 32'h0000_0000);
    check(rdata, cw);
    apb(1'b0, boot_clock_pkg::OFF_PLL_WORD, 32'h0000_0000);
    check(rdata, pw);
    check(sysKhz, expKhz(src, d, k, k));
    check(pbKhz, expKhz(src, d, k, k) >> i[2:1]);
    apb(1'b0, boot_clock_pkg::OFF_STATUS, 32'h0000_0000);
    check(rdata & 32'h0000_03E7, {22'h0, ~cw[15], 1'b0, k, 2'b00, src});
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check({rdata[30:0], rerr}, 32'h0000_0001);
    apb(1'b1, boot_clock_pkg::OFF_CONTROL, CTRL);
    apb(1'b0, boot_clock_pkg::OFF_STATUS, 32'h0000_0000);
    check(rdata & 32'h0000_00E7, {24'h0, k, 2'b00, src});
    apb(1'b1, boot_clock_pkg::OFF_UNLOCK, boot_clock_pkg::UNLOCK_KEY_A);
    apb(1'b1, boot_clock_pkg::OFF_UNLOCK, boot_clock_pkg::UNLOCK_KEY_B);
    apb(1'b1, boot_clock_pkg::OFF_CONTROL, CTRL);
    newSrc = cw[15] ? src : 3'b100;
    apb(1'b0, boot_clock_pkg::OFF_STATUS, 32'h0000_0000);
    check(rdata & 32'h0000_00E7, {24'h0, 3'b101, 2'b00, newSrc});
    apb(1'b0, boot_clock_pkg::OFF_SYS_FREQ, 32'h0000_0000);
    check(rdata, expKhz(newSrc, d, k, 3'b101));
    check(pbKhz, expKhz(newSrc, d, k, 3'b101) >> i[2:1]);
  endtask : bootAndCheck

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    clockWord = 32'hFFFF_FFFF;
    pllWord = 32'hFFFF_FFFF;
    oscFreq = '{PRI, SEC, FAST_INTERNAL_RC, LPR};
    apbReq = '0;
    failures = 0;
    checkCount = 0;
    for (int i = 0; i < 16; i++) begin
      bootAndCheck(4'(i));
    end
    completeRun();
  end

  // A hang costs a mismatch and ends the run in the usual place.
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    completeRun();
  end
endmodule : boot_clock_config_decoder_tb

bind boot_clock_config_decoder boot_clock_config_decoder_assertions #(.FRC_DIV_N(FRC_DIV_N)) checker_u (
  .clock(clock), .reset_n(reset_n), .bootClockWord(bootClockWord), .bootPllWord(bootPllWord),
  .oscFreq(oscFreq), .apbReq(apbReq), .apbRsp(apbRsp), .oscCtrl(oscCtrl), .systemClockKhz(systemClockKhz),
  .periphBusClockKhz(periphBusClockKhz), .periphBusTick(periphBusTick), .oscOutPinOut(oscOutPinOut),
  .oscOutPinOe(oscOutPinOe));
